// File: hdl/sba_engine.sv
// Serial byte access engine: config registers and two-wire bus master
// Notes on behaviour
// - After a read completes, received byte sits in the byte value register.
// - Byte value register is write data and read destination.
// - Byte offset register is sent as the byte address.
// - Address register bits 7..1 form the 7-bit target address.
// - Address register bit 0 is direction: 0 write, 1 read.
// - The three registers reset to zero only on the global reset.
// - Writing the address register starts a transfer and sets in-flight until done.
// - Missing acknowledge sets request fault; writing one clears it.
// - Short protocol uses send-byte and receive-byte, omitting the offset.
// - Serial clock near 100 kHz, faster when test clock bit set.
`timescale 1ns/1ps
`default_nettype none

module sba_engine #(
    parameter int QUARTER_NORMAL = sba_pkg::QUARTER_NORMAL_CYC,
    parameter int QUARTER_TEST   = sba_pkg::QUARTER_TEST_CYC
) (
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic       link_clk,
    input  wire logic [7:0] cfg_addr,
    input  wire logic       cfg_we,
    input  wire logic [7:0] cfg_wdata,
    output logic      [7:0] cfg_rdata,
    input  wire logic       scl_i,
    output logic            scl_o,
    output logic            scl_oe,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe
);

    ////////////////////////////////////////////////////////////////////////
    // Register side (mclk)

    logic [7:0]         byte_value_reg;
    logic [7:0]         byte_offset_reg;
    logic [7:0]         target_address_reg;
    logic               short_protocol_reg;
    logic               test_clock_reg;
    logic               in_flight_reg;
    logic               fault_reg;
    logic               req_tgl_reg;
    logic [2:0]         done_sync_reg;
    logic               done_seen_reg;
    logic               done_event;
    sba_pkg::sba_req_type req_reg;
    logic               link_done_tgl_reg;
    logic [7:0]         link_rdata_reg;
    logic               link_err_reg;

    // Done toggle counts once stages two and three agree on a new level
    assign done_event = (done_sync_reg[1] == done_sync_reg[2]) &&
                        (done_sync_reg[2] != done_seen_reg);

    // Writes other than the fault clear are ignored while busy so the link sees a stable request
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            byte_value_reg     <= sba_pkg::REG_RESET;
            byte_offset_reg    <= sba_pkg::REG_RESET;
            target_address_reg <= sba_pkg::REG_RESET;
            short_protocol_reg <= 1'b0;
            test_clock_reg     <= 1'b0;
        end else begin
            if (done_event && req_reg.read) begin
                byte_value_reg <= link_rdata_reg;
            end else if (cfg_we && !in_flight_reg
                         && cfg_addr == sba_pkg::OFS_BYTE_VALUE) begin
                byte_value_reg <= cfg_wdata;
            end
            if (cfg_we && !in_flight_reg) begin
                if (cfg_addr == sba_pkg::OFS_BYTE_OFFSET) begin
                    byte_offset_reg <= cfg_wdata;
                end else if (cfg_addr == sba_pkg::OFS_TARGET_ADDRESS) begin
                    target_address_reg <= cfg_wdata;
                end else if (cfg_addr == sba_pkg::OFS_CTRL_STATUS) begin
                    short_protocol_reg <= cfg_wdata[sba_pkg::BIT_SHORT_PROTOCOL];
                    test_clock_reg     <= cfg_wdata[sba_pkg::BIT_TEST_CLOCK];
                end
            end
        end
    end

    // Request launch and in-flight flag
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            in_flight_reg <= 1'b0;
            req_tgl_reg   <= 1'b0;
            req_reg       <= '0;
            done_seen_reg <= 1'b0;
        end else begin
            if (done_event) begin
                done_seen_reg <= done_sync_reg[2];
                in_flight_reg <= 1'b0;
            end else if (cfg_we && !in_flight_reg
                         && cfg_addr == sba_pkg::OFS_TARGET_ADDRESS) begin
                in_flight_reg       <= 1'b1;
                req_tgl_reg         <= ~req_tgl_reg;
                req_reg.target      <= cfg_wdata[7:1];
                req_reg.read        <= cfg_wdata[sba_pkg::BIT_DIRECTION];
                req_reg.offset      <= byte_offset_reg;
                req_reg.data        <= byte_value_reg;
                req_reg.short_proto <= short_protocol_reg;
                req_reg.test_clock  <= test_clock_reg;
            end
        end
    end

    // Fault flag: a new fault wins over a write-one clear
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            fault_reg <= 1'b0;
        end else if (done_event && link_err_reg) begin
            fault_reg <= 1'b1;
        end else if (cfg_we && cfg_addr == sba_pkg::OFS_CTRL_STATUS
                     && cfg_wdata[sba_pkg::BIT_REQUEST_FAULT]) begin
            fault_reg <= 1'b0;
        end
    end

    // Done toggle synchroniser
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            done_sync_reg <= 3'h0;
        end else begin
            done_sync_reg <= {done_sync_reg[1:0], link_done_tgl_reg};
        end
    end

    // Registered read data; unmapped offsets read zero
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_rdata <= 8'h00;
        end else if (cfg_addr == sba_pkg::OFS_BYTE_VALUE) begin
            cfg_rdata <= byte_value_reg;
        end else if (cfg_addr == sba_pkg::OFS_BYTE_OFFSET) begin
            cfg_rdata <= byte_offset_reg;
        end else if (cfg_addr == sba_pkg::OFS_TARGET_ADDRESS) begin
            cfg_rdata <= target_address_reg;
        end else if (cfg_addr == sba_pkg::OFS_CTRL_STATUS) begin
            cfg_rdata <= 8'h00;
            cfg_rdata[sba_pkg::BIT_SHORT_PROTOCOL] <= short_protocol_reg;
            cfg_rdata[sba_pkg::BIT_IN_FLIGHT]      <= in_flight_reg;
            cfg_rdata[sba_pkg::BIT_TEST_CLOCK]     <= test_clock_reg;
            cfg_rdata[sba_pkg::BIT_REQUEST_FAULT]  <= fault_reg;
        end else begin
            cfg_rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Link side (link_clk)

    typedef enum logic [1:0] {L_IDLE, L_START, L_BIT, L_STOP} sba_lstate_type;

    sba_lstate_type               lstate_reg;
    logic [2:0]                   req_sync_reg;
    logic                         req_seen_reg;
    logic [2:0]                   sda_sync_reg;
    logic                         sda_in_reg;
    logic [sba_pkg::TIMER_W-1:0]  timer_reg;
    logic [1:0]                   phase_reg;
    logic [3:0]                   bit_reg;
    logic [2:0]                   slot_reg;
    logic [7:0]                   shift_reg;
    logic                         tick;
    logic                         req_event;
    sba_pkg::sba_kind_type        kind;

    // Byte slot plan for the four transaction shapes
    function automatic sba_pkg::sba_kind_type slot_kind(input logic [2:0] slot,
                                                        input logic rd,
                                                        input logic short_proto);
        sba_pkg::sba_kind_type k;
        k = sba_pkg::K_END;
        if (short_proto) begin
            if (slot == 3'h0) k = rd ? sba_pkg::K_ADDR_R : sba_pkg::K_ADDR_W;
            else if (slot == 3'h1) k = rd ? sba_pkg::K_DATA_R : sba_pkg::K_DATA_W;
        end else begin
            if (slot == 3'h0) k = sba_pkg::K_ADDR_W;
            else if (slot == 3'h1) k = sba_pkg::K_OFFSET;
            else if (slot == 3'h2) k = rd ? sba_pkg::K_ADDR_R : sba_pkg::K_DATA_W;
            else if (slot == 3'h3 && rd) k = sba_pkg::K_DATA_R;
        end
        return k;
    endfunction

    // Byte to shift out for a slot
    function automatic logic [7:0] slot_byte(input sba_pkg::sba_kind_type k,
                                             input sba_pkg::sba_req_type r);
        logic [7:0] b;
        b = 8'hFF;
        case (k)
            sba_pkg::K_ADDR_W: b = {r.target, 1'b0};
            sba_pkg::K_ADDR_R: b = {r.target, 1'b1};
            sba_pkg::K_OFFSET: b = r.offset;
            sba_pkg::K_DATA_W: b = r.data;
            default:           b = 8'hFF;  // Released while receiving
        endcase
        return b;
    endfunction

    assign kind      = slot_kind(slot_reg, req_reg.read, req_reg.short_proto);
    assign req_event = (req_sync_reg[1] == req_sync_reg[2]) &&
                       (req_sync_reg[2] != req_seen_reg);
    assign tick      = (timer_reg == '0);
    assign scl_o     = 1'b0;
    assign sda_o     = 1'b0;

    // Request toggle and data pin synchronisers
    always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            req_sync_reg <= 3'h0;
            sda_sync_reg <= 3'h7;
            sda_in_reg   <= 1'b1;
        end else begin
            req_sync_reg <= {req_sync_reg[1:0], req_tgl_reg};
            sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
            if (sda_sync_reg[1] == sda_sync_reg[2]) begin
                sda_in_reg <= sda_sync_reg[2];
            end
        end
    end

    // Quarter-bit timer; request fields stay stable while in flight
    always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            timer_reg <= '0;
        end else if (lstate_reg == L_IDLE || tick) begin
            timer_reg <= req_reg.test_clock ?
                         sba_pkg::TIMER_W'(QUARTER_TEST - 1) :
                         sba_pkg::TIMER_W'(QUARTER_NORMAL - 1);
        end else begin
            timer_reg <= timer_reg - 1'b1;
        end
    end

    // Bus sequencer: open-drain enables pull the lines low
    always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            lstate_reg        <= L_IDLE;
            req_seen_reg      <= 1'b0;
            phase_reg         <= 2'h0;
            bit_reg           <= 4'h0;
            slot_reg          <= 3'h0;
            shift_reg         <= 8'h00;
            scl_oe            <= 1'b0;
            sda_oe            <= 1'b0;
            link_done_tgl_reg <= 1'b0;
            link_rdata_reg    <= 8'h00;
            link_err_reg      <= 1'b0;
        end else begin
            case (lstate_reg)
                L_IDLE: begin
                    phase_reg <= 2'h0;
                    if (req_event) begin
                        req_seen_reg <= req_sync_reg[2];
                        slot_reg     <= 3'h0;
                        link_err_reg <= 1'b0;
                        lstate_reg   <= L_START;
                    end
                end
                L_START: if (tick) begin
                    // Also serves as repeated start, entered with clock low
                    phase_reg <= phase_reg + 1'b1;
                    case (phase_reg)
                        2'h0:    sda_oe <= 1'b0;
                        2'h1:    scl_oe <= 1'b0;
                        2'h2:    sda_oe <= 1'b1;
                        default: begin
                            scl_oe     <= 1'b1;
                            bit_reg    <= 4'h0;
                            shift_reg  <= slot_byte(kind, req_reg);
                            lstate_reg <= L_BIT;
                        end
                    endcase
                end
                L_BIT: if (tick) begin
                    phase_reg <= phase_reg + 1'b1;
                    case (phase_reg)
                        2'h0: begin
                            // Acknowledge slot is released: nack on the read byte
                            sda_oe <= (bit_reg != sba_pkg::LAST_BIT) && !shift_reg[7];
                        end
                        2'h1: scl_oe <= 1'b0;
                        2'h2: begin
                            if (bit_reg != sba_pkg::LAST_BIT) begin
                                shift_reg <= {shift_reg[6:0], sda_in_reg};
                            end else if (kind != sba_pkg::K_DATA_R && sda_in_reg) begin
                                link_err_reg <= 1'b1;
                            end
                        end
                        default: begin
                            scl_oe <= 1'b1;
                            if (bit_reg != sba_pkg::LAST_BIT) begin
                                bit_reg <= bit_reg + 1'b1;
                            end else begin
                                if (kind == sba_pkg::K_DATA_R) begin
                                    link_rdata_reg <= shift_reg;
                                end
                                bit_reg  <= 4'h0;
                                slot_reg <= slot_reg + 1'b1;
                                if (link_err_reg || slot_kind(slot_reg + 3'h1, req_reg.read,
                                        req_reg.short_proto) == sba_pkg::K_END) begin
                                    lstate_reg <= L_STOP;
                                end else if (slot_kind(slot_reg + 3'h1, req_reg.read,
                                        req_reg.short_proto) == sba_pkg::K_ADDR_R) begin
                                    lstate_reg <= L_START;
                                end else begin
                                    shift_reg <= slot_byte(slot_kind(slot_reg + 3'h1,
                                        req_reg.read, req_reg.short_proto), req_reg);
                                end
                            end
                        end
                    endcase
                end
                default: if (tick) begin
                    phase_reg <= phase_reg + 1'b1;
                    case (phase_reg)
                        2'h0:    sda_oe <= 1'b1;
                        2'h1:    scl_oe <= 1'b0;
                        2'h2:    sda_oe <= 1'b0;
                        default: begin
                            link_done_tgl_reg <= ~link_done_tgl_reg;
                            lstate_reg        <= L_IDLE;
                        end
                    endcase
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// File: hdl/sba_pkg.sv
// Package of constants and types for the serial byte access engine
package sba_pkg;

    // Register offsets in configuration space
    localparam logic [7:0] OFS_BYTE_VALUE     = 8'hB0;
    localparam logic [7:0] OFS_BYTE_OFFSET    = 8'hB1;
    localparam logic [7:0] OFS_TARGET_ADDRESS = 8'hB2;
    localparam logic [7:0] OFS_CTRL_STATUS    = 8'hB3;

    // Control/status bit positions
    localparam int BIT_SHORT_PROTOCOL = 7;
    localparam int BIT_IN_FLIGHT      = 5;
    localparam int BIT_TEST_CLOCK     = 2;
    localparam int BIT_REQUEST_FAULT  = 1;

    // Target address register fields and register reset value
    localparam int BIT_DIRECTION = 0;
    localparam logic [7:0] REG_RESET = 8'h00;

    // Serial clock timing, link clock period in ns
    localparam int LINK_PERIOD_NS    = 32;
    localparam int SCL_NORMAL_KHZ    = 100;
    localparam int SCL_TEST_KHZ      = 400;
    localparam int QUARTER_NORMAL_NS = 1_000_000 / (SCL_NORMAL_KHZ * 4);
    localparam int QUARTER_TEST_NS   = 1_000_000 / (SCL_TEST_KHZ * 4);
    // Longest time per quarter: round down, at least one cycle
    localparam int QUARTER_NORMAL_CYC = (QUARTER_NORMAL_NS / LINK_PERIOD_NS) > 0 ?
                                        (QUARTER_NORMAL_NS / LINK_PERIOD_NS) : 1;
    localparam int QUARTER_TEST_CYC   = (QUARTER_TEST_NS / LINK_PERIOD_NS) > 0 ?
                                        (QUARTER_TEST_NS / LINK_PERIOD_NS) : 1;
    localparam int TIMER_W = 12;

    localparam logic [3:0] LAST_BIT = 4'h8;  // Ninth bit is the acknowledge
    localparam logic [1:0] LAST_PHASE = 2'h3;

    // Byte slot kinds within one transaction
    typedef enum logic [2:0] {
        K_ADDR_W, K_OFFSET, K_DATA_W, K_ADDR_R, K_DATA_R, K_END
    } sba_kind_type;

    // Request handed from the register side to the link side
    typedef struct packed {
        logic [6:0] target;
        logic       read;
        logic [7:0] offset;
        logic [7:0] data;
        logic       short_proto;
        logic       test_clock;
    } sba_req_type;

endpackage

// File: testbench/sba_engine_chk.sv
// Checker of register read-back and two-wire line timing for the engine
`timescale 1ns/1ps
`default_nettype none
module sba_engine_chk #(
    parameter int QUARTER_NORMAL = 4,
    parameter int QUARTER_TEST   = 2
) (
    input wire logic       mclk,
    input wire logic       sys_rst,
    input wire logic       link_clk,
    input wire logic [7:0] cfg_addr,
    input wire logic       cfg_we,
    input wire logic [7:0] cfg_wdata,
    input wire logic [7:0] cfg_rdata,
    input wire logic       scl_o,
    input wire logic       scl_oe,
    input wire logic       sda_o,
    input wire logic       sda_oe
);
    localparam int START_MAX = 100;
    logic [11:0] low_cnt_reg;
    ////////////////////////////////////////////////////////////////////////////
    // Length of the SCL low phase; idle highs are unbounded, so only lows are timed
    always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            low_cnt_reg <= 12'h000;
        end else begin
            low_cnt_reg <= scl_oe ? low_cnt_reg + 12'h001 : 12'h000;
        end
    end
    // Start and stop are SDA edges while SCL is released
    sequence start_s;
        $rose(sda_oe) && !scl_oe;
    endsequence
    sequence stop_s;
        $fell(sda_oe) && !scl_oe;
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    scl_low_len_a: assert property (@(posedge link_clk) disable iff (sys_rst)
        $fell(scl_oe) |-> low_cnt_reg >= 12'(2 * QUARTER_TEST)
            && low_cnt_reg <= 12'(2 * QUARTER_NORMAL))
        else $error("scl low phase has wrong length");
    sda_skew_a: assert property (@(posedge link_clk) disable iff (sys_rst)
        $changed(scl_oe) |-> $stable(sda_oe))
        else $error("sda moved together with scl");
    start_clock_a: assert property (@(posedge link_clk) disable iff (sys_rst)
        start_s |-> ##[1:START_MAX] scl_oe)
        else $error("no clock after start");
    stop_free_a: assert property (@(posedge link_clk) disable iff (sys_rst)
        stop_s |-> (!scl_oe && !sda_oe) [*2])
        else $error("bus not free after stop");
    open_drain_a: assert property (@(posedge link_clk) disable iff (sys_rst)
        !scl_o && !sda_o)
        else $error("line driven high");
    unmapped_zero_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (cfg_addr < sba_pkg::OFS_BYTE_VALUE || cfg_addr > sba_pkg::OFS_CTRL_STATUS)
            |=> cfg_rdata == 8'h00)
        else $error("unmapped read not zero");
    status_rsvd_a: assert property (@(posedge mclk) disable iff (sys_rst)
        cfg_addr == sba_pkg::OFS_CTRL_STATUS |=> cfg_rdata[6] == 1'b0
            && cfg_rdata[4:3] == 2'h0 && cfg_rdata[0] == 1'b0)
        else $error("reserved status bits set");
    offset_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (cfg_addr == sba_pkg::OFS_BYTE_OFFSET && !cfg_we) ##1
            (cfg_addr == sba_pkg::OFS_BYTE_OFFSET && !cfg_we) |=> $stable(cfg_rdata))
        else $error("offset changed without a write");
    fault_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (cfg_we && cfg_addr == sba_pkg::OFS_CTRL_STATUS && cfg_wdata[1]) ##1
            (cfg_addr == sba_pkg::OFS_CTRL_STATUS) |=> !cfg_rdata[1])
        else $error("fault flag not cleared");
endmodule
bind sba_engine sba_engine_chk #(
    .QUARTER_NORMAL(QUARTER_NORMAL),
    .QUARTER_TEST  (QUARTER_TEST)
) u_sba_engine_chk (
    .mclk(mclk), .sys_rst(sys_rst), .link_clk(link_clk), .cfg_addr(cfg_addr),
    .cfg_we(cfg_we), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe)
);
`default_nettype wire

// File: testbench/sba_tgt_model.sv
// Two-wire target model with a byte memory and an address pointer
`timescale 1ns/1ps
`default_nettype none
module sba_tgt_model #(
    parameter logic [6:0] DEV_ADDR = 7'h2C
) (
    input  wire logic scl,
    input  wire logic sda,
    output logic      sda_pull
);
    logic [7:0] mem [0:255];
    logic [7:0] rx_q [$];
    logic [7:0] sh, txb, ptr;
    logic       act, hit, tx;
    int         bc, nb, starts;
    ////////////////////////////////////////////////////////////////////////////
    // Start resets framing; stop ends it
    initial sda_pull = 1'b0;
    initial act = 1'b0;
    initial starts = 0;
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            act = 1'b1;
            bc = 0;
            nb = 0;
            tx = 1'b0;
            hit = 1'b0;
            starts++;
        end
    end
    always @(posedge sda) if (scl === 1'b1) act = 1'b0;
    // Sample on the rising edge; a released ninth bit from the host ends a read
    always @(posedge scl) begin
        if (bc < 8) sh = {sh[6:0], sda};
        else if (tx && sda) hit = 1'b0;
        bc = (bc == 8) ? 0 : bc + 1;
    end
    // Change the drive only as SCL falls; a wrong address is left unanswered
    always @(negedge scl) begin
        if (act && bc == 8 && !tx) begin
            rx_q.push_back(sh);
            if (nb == 0) begin
                hit = sh[7:1] == DEV_ADDR;
                tx = sh[0];
            end else if (nb == 1) begin
                ptr = sh;
            end else begin
                mem[ptr] = sh;
            end
            sda_pull = hit;
            nb++;
        end else if (act && tx && hit && bc < 8) begin
            if (bc == 0) begin
                txb = mem[ptr];
                ptr++;
            end
            sda_pull = !txb[7 - bc];
        end else begin
            sda_pull = 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: testbench/host_serial_bus_byte_access_test.sv
// Testbench for the serial byte access engine against a two-wire target
`timescale 1ns/1ps
`default_nettype none
module host_serial_bus_byte_access_test;
    localparam logic [7:0] A_VAL = sba_pkg::OFS_BYTE_VALUE;
    localparam logic [7:0] A_OFS = sba_pkg::OFS_BYTE_OFFSET;
    localparam logic [7:0] A_TGT = sba_pkg::OFS_TARGET_ADDRESS;
    localparam logic [7:0] A_CSR = sba_pkg::OFS_CTRL_STATUS;
    localparam int         QN = 4;
    localparam int         QT = 2;
    localparam logic [6:0] DEV = 7'h2C;
    logic       mclk = 1'b0;
    logic       link_clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       cfg_we = 1'b0;
    logic [7:0] cfg_addr = 8'h00;
    logic [7:0] cfg_wdata = 8'h00;
    logic [7:0] cfg_rdata;
    logic       scl_o, scl_oe, sda_o, sda_oe, tgt_pull;
    int         miscompares = 0;
    int         comparisons = 0;
    // Open-drain lines with pull-ups
    wire        scl_line = ~scl_oe;
    wire        sda_line = ~(sda_oe | tgt_pull);
    sba_engine #(.QUARTER_NORMAL(QN), .QUARTER_TEST(QT)) u_sba_engine (
        .mclk(mclk), .sys_rst(sys_rst), .link_clk(link_clk), .cfg_addr(cfg_addr),
        .cfg_we(cfg_we), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .scl_i(scl_line),
        .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe)
    );
    sba_tgt_model #(.DEV_ADDR(DEV)) u_sba_tgt_model (
        .scl(scl_line), .sda(sda_line), .sda_pull(tgt_pull)
    );
    ////////////////////////////////////////////////////////////////////////////
    // Clocks; the link clock is offset so the two never share edges
    always #4 mclk = ~mclk;
    initial begin
        #3.3;
        forever #16 link_clk = ~link_clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1 cfg_addr = a;
        cfg_wdata = d;
        cfg_we = 1'b1;
        @(posedge mclk);
        #1 cfg_we = 1'b0;
    endtask
    // Read data is registered, so it is taken one edge after the address
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        #1 cfg_addr = a;
        @(posedge mclk);
        #1 d = cfg_rdata;
    endtask
    // Poll the in-flight bit under a bound so a stuck engine cannot hang
    task automatic wait_idle();
        logic [7:0] s = 8'h20;
        for (int i = 0; i < 4000 && s[5] !== 1'b0; i++) reg_rd(A_CSR, s);
        check(s[5], 1'b0);
    endtask
    task automatic chk_rx(input int n, input logic [23:0] e);
        check(16'(u_sba_tgt_model.rx_q.size()), 16'(n));
        for (int i = 0; i < n; i++) check(u_sba_tgt_model.rx_q[i], e[23 - 8 * i -: 8]);
    endtask
    // Width of the first SCL low phase after a request, in ns
    task automatic low_width(input int q);
        realtime t0;
        @(posedge scl_oe);
        t0 = $realtime;
        @(negedge scl_oe);
        check(16'(int'($realtime - t0)), 16'(2 * q * 32));
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [7:0] d;
        @(posedge mclk);
        #1 sys_rst = 1'b1;
        repeat (12) @(posedge mclk);
        #1 sys_rst = 1'b0;
        for (int i = 0; i < 5; i++) begin
            reg_rd((i < 4) ? A_VAL + 8'(i) : 8'hA6, d);
            check(d, 8'h00);
        end
        $display("reset test done");
    endtask
    task automatic t_write();
        logic [7:0] d;
        reg_wr(A_VAL, 8'hA5);
        reg_wr(A_OFS, 8'h7E);
        u_sba_tgt_model.rx_q.delete();
        reg_wr(A_TGT, {DEV, 1'b0});
        reg_rd(A_CSR, d);
        check(d[5], 1'b1);
        low_width(QN);
        reg_wr(A_OFS, 8'h11);
        wait_idle();
        reg_rd(A_OFS, d);
        check(d, 8'h7E);
        chk_rx(3, {DEV, 1'b0, 16'h7EA5});
        check(u_sba_tgt_model.mem[8'h7E], 8'hA5);
        $display("write test done");
    endtask
    task automatic t_read();
        logic [7:0] d;
        int         n0;
        reg_wr(A_VAL, 8'h00);
        reg_wr(A_OFS, 8'h7E);
        u_sba_tgt_model.rx_q.delete();
        n0 = u_sba_tgt_model.starts;
        reg_wr(A_TGT, {DEV, 1'b1});
        wait_idle();
        reg_rd(A_VAL, d);
        check(d, 8'hA5);
        reg_rd(A_TGT, d);
        check(d, {DEV, 1'b1});
        chk_rx(3, {DEV, 1'b0, 8'h7E, DEV, 1'b1});
        check(16'(u_sba_tgt_model.starts - n0), 16'h0002);
        $display("read test done");
    endtask
    task automatic t_fault();
        logic [7:0] d;
        reg_wr(A_TGT, {~DEV, 1'b0});
        wait_idle();
        reg_rd(A_CSR, d);
        check(d, 8'h02);
        reg_wr(A_CSR, 8'h02);
        reg_rd(A_CSR, d);
        check(d, 8'h00);
        $display("fault test done");
    endtask
    task automatic t_short();
        logic [7:0] d;
        reg_wr(A_CSR, 8'h84);
        reg_wr(A_VAL, 8'h7E);
        u_sba_tgt_model.rx_q.delete();
        reg_wr(A_TGT, {DEV, 1'b0});
        low_width(QT);
        wait_idle();
        chk_rx(2, {DEV, 1'b0, 16'h7E00});
        reg_wr(A_VAL, 8'h00);
        reg_wr(A_TGT, {DEV, 1'b1});
        wait_idle();
        reg_rd(A_VAL, d);
        check(d, 8'hA5);
        reg_rd(A_CSR, d);
        check(d, 8'h84);
        reg_wr(A_CSR, 8'h00);
        $display("short protocol test done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence; a second reset in mid-run closes it
    initial begin
        t_reset();
        t_write();
        t_read();
        t_fault();
        t_short();
        t_reset();
        tally_and_finish();
    end
    // Watchdog well beyond the few tens of microseconds the tests need
    initial begin
        #600_000;
        miscompares++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
